// File: dv/adct_ctrl_tb.sv
// Purpose: self-checking bench for the ADC sample/convert sequencer
// Assumes: host model drives the pins at the falling clock edge
// Notes: one SCLK period spans four logic clocks
`timescale 1ns/1ps
module adct_ctrl_tb
   import adct_pkg::*;
   ;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   adct_pins_t pins;
   adct_cfg_t cfg = '0;
   logic [RESULT_W-1:0] conv_data = '0;
   logic fifo_ready = 1'b0;
   logic sampling, converting, eoc, int_n, ext_mode, pwrdn, result_valid, fifo_valid;
   logic [RESULT_W-1:0] result, fifo_data;
   int failures = 0;
   int n_compared = 0;
   int s_len, c_len, n;
   logic [1:0] clk_tab [3] = '{CLK_SCLK, CLK_SCLK_DIV2, CLK_SCLK_DIV4};
   logic [3:0] cmd_tab [3] = '{4'h3, 4'hb, 4'hd};
   int div_tab [3] = '{1, 2, 4};

   always #20 ref_clk_i = ~ref_clk_i;

   adct_host_model u_adct_host_model (.ref_clk_i(ref_clk_i), .pins_o(pins));

   adct_ctrl u_adct_ctrl (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .cfg_i(cfg), .conv_data_i(conv_data),
      .sampling_o(sampling), .converting_o(converting), .eoc_o(eoc), .int_n_o(int_n),
      .ext_mode_o(ext_mode), .pwrdn_o(pwrdn), .result_valid_o(result_valid), .result_o(result),
      .fifo_valid_o(fifo_valid), .fifo_ready_i(fifo_ready), .fifo_data_o(fifo_data)
   );

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic end_test(input string name);
      $display("test %s done, failures so far %0d", name, failures);
   endtask

   task automatic wait_lvl(ref logic s, input logic v, output int cnt);
      cnt = 0;
      while (s !== v && cnt < 2000)
      begin
         @(negedge ref_clk_i);
         cnt++;
      end
      if (cnt >= 2000)
      begin
         failures++;
         $display("wrong value wait level: expected %b, seen %b", v, s);
         summarize();
      end
   endtask

   // Cycles spent sampling, then cycles spent converting
   task automatic measure(output int sl, output int cl);
      int w;
      wait_lvl(sampling, 1'b1, w);
      wait_lvl(sampling, 1'b0, sl);
      wait_lvl(converting, 1'b0, cl);
   endtask

   task automatic normal_run(input logic [3:0] cmd, input int nclk, input bit use_fs);
      fork
         u_adct_host_model.frame(cmd, nclk, use_fs);
         measure(s_len, c_len);
      join
   endtask

   initial
   begin
      repeat (8) @(negedge ref_clk_i);
      check("reset flags", 16'({sampling, converting, eoc, int_n, ext_mode, pwrdn, result_valid, fifo_valid}),
         16'h0010);
      check("reset result", 16'(result), 16'h0000);
      repeat (8) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      end_test("reset");

      conv_data = 12'h5a3;
      normal_run(4'h0, 18, 1'b0);
      check("short sample cycles", 16'(s_len), 16'h0030);
      check("internal clock conv cycles", 16'(c_len), 16'(CONV_INT_CYC));
      check("one-shot result", 16'(result), 16'h05a3);
      check("result valid and int", 16'({result_valid, int_n}), 16'h0002);
      end_test("one-shot");

      u_adct_host_model.frame(4'h8, 16, 1'b0);
      repeat (6) @(negedge ref_clk_i);
      check("power down", 16'({pwrdn, sampling, converting}), 16'h0004);
      cfg.long_sample = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         cfg.conv_clk = clk_tab[k];
         normal_run(cmd_tab[k], 30 + div_tab[k] * 14, 1'b0);
         check("long sample cycles", 16'(s_len), 16'h0060);
         check("sclk conv cycles", 16'(c_len), 16'(div_tab[k] * 56));
      end
      check("power down cleared", 16'(pwrdn), 16'h0000);
      end_test("sclk clocks");

      cfg = '0;
      u_adct_host_model.cs_level(1'b0);
      repeat (8) @(negedge ref_clk_i);
      for (int k = 0; k < 2; k++)
      begin
         normal_run(4'h0, 18, 1'b1);
         check("frame sync sample cycles", 16'(s_len), 16'h0030);
      end
      u_adct_host_model.cs_level(1'b1);
      end_test("frame sync");

      cfg.conv_mode = MODE_REPEAT;
      fork
         u_adct_host_model.ext_sample(20);
         begin
            repeat (10) @(negedge ref_clk_i);
            check("pin refused", 16'({sampling, ext_mode}), 16'h0000);
         end
      join
      repeat (6) @(negedge ref_clk_i);
      check("no conversion", 16'(converting), 16'h0000);
      end_test("pin refused");

      cfg.ref_int = 1'b1;
      conv_data = 12'h3e1;
      fork
         u_adct_host_model.frame(4'h1, 8, 1'b0);
         begin
            wait_lvl(sampling, 1'b1, n);
            u_adct_host_model.ext_sample(30);
         end
         begin
            repeat (27) @(negedge ref_clk_i);
            check("pending sample", 16'({sampling, converting}), 16'h0000);
            measure(s_len, c_len);
         end
      join
      check("early pin sample cycles", 16'(s_len), 16'h0010);
      check("early pin conv cycles", 16'(c_len), 16'(CONV_INT_CYC));
      check("early pin fifo word", 16'({fifo_valid, fifo_data}), 16'h13e1);
      fifo_ready = 1'b1;
      @(negedge ref_clk_i);
      fifo_ready = 1'b0;
      check("early pin fifo empty", 16'(fifo_valid), 16'h0000);
      end_test("early pin");

      cfg.conv_mode = MODE_ONESHOT;
      conv_data = 12'h2c7;
      fork
         u_adct_host_model.ext_sample(40);
         measure(s_len, c_len);
      join
      check("ext sample cycles", 16'(s_len), 16'h0028);
      check("ext conv cycles", 16'(c_len), 16'(CONV_INT_CYC));
      check("ext mode and result", 16'({ext_mode, result}), 16'h12c7);
      u_adct_host_model.frame(4'he, 16, 1'b0);
      repeat (6) @(negedge ref_clk_i);
      check("ext after one fall", 16'({ext_mode, sampling}), 16'h0002);
      u_adct_host_model.frame(4'ha, 16, 1'b0);
      repeat (6) @(negedge ref_clk_i);
      check("ext mode left", 16'(ext_mode), 16'h0000);
      end_test("extended");

      cfg.conv_mode = MODE_REPEAT;
      cfg.ref_int = 1'b1;
      cfg.eoc_sel = 1'b1;
      for (int k = 0; k < 17; k++)
      begin
         conv_data = 12'(12'h100 + k);
         fork
            u_adct_host_model.ext_sample(20);
            begin
               wait_lvl(sampling, 1'b1, n);
               wait_lvl(sampling, 1'b0, n);
               check("eoc while converting", 16'({eoc, converting}), 16'h0003);
            end
         join
         if (k < 16)
            wait_lvl(converting, 1'b0, n);
      end
      repeat (150) @(negedge ref_clk_i);
      check("stall while full", 16'({converting, fifo_valid}), 16'h0003);
      for (int j = 0; j < 17; j++)
      begin
         repeat (3) @(negedge ref_clk_i);
         check("fifo word", 16'({fifo_valid, fifo_data}), 16'(13'h1100 + j));
         fifo_ready = 1'b1;
         @(negedge ref_clk_i);
         fifo_ready = 1'b0;
      end
      repeat (2) @(negedge ref_clk_i);
      check("fifo drained", 16'({fifo_valid, converting}), 16'h0000);
      end_test("repeat fifo");
      summarize();
   end
endmodule

// File: dv/adct_host_model.sv
// Purpose: host serial port model driving the sequencer pins
// Assumes: pins change only at the falling logic clock edge
// Notes: SCLK idles low between frames; SDI shows the inverse of its last bit once released
`timescale 1ns/1ps
module adct_host_model
   import adct_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Pins to the device
   output adct_pins_t pins_o
);
   initial pins_o = PINS_IDLE;

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   task automatic cs_level(input logic v);
      tick(1);
      pins_o.cs_n = v;
   endtask

   // Frame: command MSB first on the first four rises, zeros after
   task automatic frame(input logic [3:0] cmd, input int nclk, input bit use_fs);
      tick(1);
      if (use_fs)
      begin
         pins_o.dsp_frame_sync = 1'b1;
         tick(2);
         pins_o.dsp_frame_sync = 1'b0;
      end
      else
         pins_o.cs_n = 1'b0;
      tick(2);
      for (int i = 0; i < nclk; i++)
      begin
         pins_o.sdi = (i < 4) ? cmd[3 - i] : 1'b0;
         tick(2);
         pins_o.sclk = 1'b1;
         tick(2);
         pins_o.sclk = 1'b0;
      end
      if (!use_fs)
         pins_o.cs_n = 1'b1;
      pins_o.sdi = ~pins_o.sdi;
   endtask

   // One trigger type per run; low time well above the sample minimum
   task automatic ext_sample(input int low_cyc);
      tick(1);
      pins_o.ext_sample_start_n = 1'b0;
      tick(low_cyc);
      pins_o.ext_sample_start_n = 1'b1;
   endtask
endmodule

// File: inc/adct_pkg.sv
// Purpose: shared constants and types of the ADC sample/convert sequencer
// Assumes: 25 MHz logic clock, pins sampled asynchronously
// Notes: config word layout follows the 12-bit control word
package adct_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_MAX_NS = 3860;
   localparam int CONV_INT_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int REP_GAP_NS = 2000;
   localparam int REP_GAP_CYC = (REP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESULT_W = 12;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] CMD_LAST_EDGE = 5'h03;
   localparam logic [4:0] SHORT_START_EDGE = 5'h10;
   localparam logic [4:0] LONG_START_EDGE = 5'h1c;
   localparam logic [5:0] SCLK_CONV_PERIODS = 6'h0e;
   localparam logic [1:0] MODE_ONESHOT = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_SWEEP = 2'h2;
   localparam logic [1:0] MODE_REP_SWEEP = 2'h3;
   localparam logic [1:0] CLK_INTERNAL = 2'h0;
   localparam logic [1:0] CLK_SCLK = 2'h1;
   localparam logic [1:0] CLK_SCLK_DIV4 = 2'h2;
   localparam logic [1:0] CLK_SCLK_DIV2 = 2'h3;
   localparam logic [3:0] CMD_CH_LAST = 4'h7;
   localparam logic [3:0] CMD_PWRDN = 4'h8;
   localparam logic [3:0] CMD_TEST_FIRST = 4'hb;
   localparam logic [3:0] CMD_TEST_LAST = 4'hd;
   localparam logic [3:0] CMD_FIFO_READ = 4'he;

   typedef struct packed {
      logic ref_int;
      logic ref_2v;
      logic long_sample;
      logic [1:0] conv_clk;
      logic [1:0] conv_mode;
      logic [1:0] sweep_seq;
      logic eoc_sel;
      logic [1:0] fifo_lvl;
   } adct_cfg_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic dsp_frame_sync;
      logic sdi;
      logic ext_sample_start_n;
   } adct_pins_t;

   localparam adct_pins_t PINS_IDLE = 5'h09;

   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_SAMPLE, ST_CONV} adct_state_t;

   function automatic logic is_conv_cmd(input logic [3:0] cmd);
      is_conv_cmd = (cmd <= CMD_CH_LAST) || (cmd >= CMD_TEST_FIRST && cmd <= CMD_TEST_LAST);
   endfunction

   function automatic logic [5:0] sclk_conv_edges(input logic [1:0] src);
      unique case (src)
         CLK_SCLK: sclk_conv_edges = SCLK_CONV_PERIODS;
         CLK_SCLK_DIV2: sclk_conv_edges = 6'(SCLK_CONV_PERIODS << 1);
         CLK_SCLK_DIV4: sclk_conv_edges = 6'(SCLK_CONV_PERIODS << 2);
         default: sclk_conv_edges = 6'h00;
      endcase
   endfunction
endpackage

// File: rtl/adct_ctrl.sv
// Purpose: sampling and conversion sequencer of a serial 12-bit ADC
// Assumes: pins are asynchronous; cfg_i and conv_data_i are on ref_clk_i
// Notes: SCLK is oversampled, so it must stay well below the logic clock
// Contract
// R01 - Sampling starts only after conversion command
// R02 - Normal sampling lasts 12 or 24 SCLKs
// R03 - Host picks long sampling above 10 MHz
// R04 - Start pin fall with CS high samples
// R05 - Host holds start pin low minimum time
// R06 - Repeat mode: early pin waits for CS
// R07 - Start pin rise ends sample, converts
// R08 - Buffered result presented on next read
// R09 - Two CS falls, pin high, leave extended
// R10 - Pin trigger in modes 01-11 needs internal ref
// R11 - Convert after SCLK edge 16 or 28
// R12 - Oscillator conversion within 3.86 us
// R13 - SCLK conversion takes 14 divided periods
// R14 - Non-conversion commands still acted upon
// R15 - Four modes; pin, CS, frame sync triggers
// R16 - Frame sync works with CS held low
// R17 - Host never mixes trigger types
// R18 - Host spaces triggers past conversion time
// R19 - One-shot bypasses FIFO; EOC or INT
// R20 - Repeat mode fills FIFO, restart drops it
// R21 - Configuration kept between sequences
// R22 - Early pulse converts after 2 us gap
// R23 - Mode field decode 00/01/10/11; code decodes only 00 and 01, 10/11 fill FIFO like 01
// R24 - Sample select bit picks 12 or 24
// R25 - Clock source field decode
// R26 - Reference select bit picks internal
// R27 - Start pin synchronised, edges detected
`timescale 1ns/1ps
module adct_ctrl
   import adct_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Serial port and start pin
   input wire adct_pins_t pins_i,
   // Configuration and analog result
   input wire adct_cfg_t cfg_i,
   input wire logic [RESULT_W-1:0] conv_data_i,
   // Status
   output logic sampling_o,
   output logic converting_o,
   output logic eoc_o,
   output logic int_n_o,
   output logic ext_mode_o,
   output logic pwrdn_o,
   // One-shot result
   output logic result_valid_o,
   output logic [RESULT_W-1:0] result_o,
   // FIFO drain
   output logic fifo_valid_o,
   input wire logic fifo_ready_i,
   output logic [RESULT_W-1:0] fifo_data_o
);
   adct_pins_t pin_meta;
   adct_pins_t pin_sync;
   adct_pins_t pin_prev;
   adct_state_t state;
   logic [4:0] edge_cnt;
   logic [3:0] cmd_sh;
   logic ext_smp;
   logic ext_pend;
   logic [6:0] gap_cnt;
   logic [6:0] conv_cnt;
   logic [5:0] sclk_cnt;
   logic cs_fall_seen;
   logic push_ready;
   logic fifo_flush;

   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;
   logic frame_sync_rise;
   logic ext_fall;
   logic ext_rise;
   logic cs_high;
   logic ext_ok;
   logic frame_start;
   logic cmd_done;
   logic [3:0] cmd_next;
   logic [4:0] start_edge;
   logic oneshot;
   logic conv_elapsed;
   logic conv_done;
   logic gap_done;

   // Two-stage sync, then edge detect on the second stage
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_meta <= PINS_IDLE;
         pin_sync <= PINS_IDLE;
         pin_prev <= PINS_IDLE;
      end
      else
      begin
         pin_meta <= pins_i; // [R27]
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign sclk_rise = pin_sync.sclk && !pin_prev.sclk;
   assign cs_fall = !pin_sync.cs_n && pin_prev.cs_n;
   assign cs_rise = pin_sync.cs_n && !pin_prev.cs_n;
   assign frame_sync_rise = pin_sync.dsp_frame_sync && !pin_prev.dsp_frame_sync;
   assign ext_fall = !pin_sync.ext_sample_start_n && pin_prev.ext_sample_start_n; // [R27]
   assign ext_rise = pin_sync.ext_sample_start_n && !pin_prev.ext_sample_start_n; // [R27]
   assign cs_high = pin_sync.cs_n;

   assign oneshot = cfg_i.conv_mode == MODE_ONESHOT; // [R23]
   assign ext_ok = oneshot || cfg_i.ref_int; // [R10] [R26]
   assign frame_start = cs_fall || (frame_sync_rise && !cs_high); // [R15] [R16]
   assign cmd_next = {cmd_sh[2:0], pin_sync.sdi};
   assign cmd_done = state == ST_CMD && sclk_rise && edge_cnt == CMD_LAST_EDGE;
   assign start_edge = cfg_i.long_sample ? LONG_START_EDGE : SHORT_START_EDGE; // [R24] [R02]
   assign gap_done = ext_pend && pin_sync.ext_sample_start_n && gap_cnt >= 7'(REP_GAP_CYC);

   // Conversion length by clock source
   always_comb
   begin
      if (cfg_i.conv_clk == CLK_INTERNAL) // [R25]
         conv_elapsed = conv_cnt >= 7'(CONV_INT_CYC); // [R12]
      else
         // Rise taken now counts, so the last period ends it
         conv_elapsed = 7'(sclk_cnt) + 7'(sclk_rise) >= 7'(sclk_conv_edges(cfg_i.conv_clk)); // [R13]
   end

   // A full FIFO stalls the end of conversion
   assign conv_done = state == ST_CONV && conv_elapsed && (oneshot || push_ready); // [R19]

   // Sequencer
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= ST_IDLE;
         edge_cnt <= '0;
         cmd_sh <= '0;
         ext_smp <= 1'b0;
         ext_pend <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (ext_fall && cs_high && ext_ok)
               begin
                  state <= ST_SAMPLE; // [R04]
                  ext_smp <= 1'b1;
               end
               else if (frame_start)
               begin
                  state <= ST_CMD;
                  edge_cnt <= '0;
               end
            end
            ST_CMD:
            begin
               if (sclk_rise)
               begin
                  cmd_sh <= cmd_next;
                  edge_cnt <= edge_cnt + 5'h01;
               end
               if (cmd_done)
               begin
                  if (is_conv_cmd(cmd_next) && !ext_mode_o)
                  begin
                     state <= ST_SAMPLE; // [R01]
                     ext_smp <= 1'b0;
                  end
                  else
                     state <= ST_IDLE; // [R14] [R08]
               end
               else if (cs_rise)
                  state <= ST_IDLE;
            end
            ST_SAMPLE:
            begin
               if (ext_smp)
               begin
                  if (ext_rise || gap_done)
                  begin
                     state <= ST_CONV; // [R07] [R22]
                     ext_pend <= 1'b0;
                  end
               end
               else if (ext_pend)
               begin
                  if (cs_rise)
                     ext_smp <= 1'b1; // [R06]
               end
               else if (ext_fall && !cs_high && ext_ok && cfg_i.conv_mode == MODE_REPEAT)
                  ext_pend <= 1'b1; // [R06]
               else if (sclk_rise && edge_cnt + 5'h01 == start_edge)
                  state <= ST_CONV; // [R11] [R02]
               else if (cs_rise)
                  state <= ST_IDLE;
               if (!ext_smp && sclk_rise)
                  edge_cnt <= edge_cnt + 5'h01;
            end
            ST_CONV:
            begin
               ext_smp <= 1'b0;
               if (conv_done)
                  state <= ST_IDLE;
            end
         endcase
      end
   end

   // Conversion and repeat-gap timers
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         conv_cnt <= '0;
         sclk_cnt <= '0;
         gap_cnt <= '0;
      end
      else
      begin
         if (state != ST_CONV)
         begin
            conv_cnt <= 7'h01;
            sclk_cnt <= '0;
         end
         else
         begin
            if (conv_cnt < 7'(CONV_INT_CYC))
               conv_cnt <= conv_cnt + 7'h01;
            if (sclk_rise && sclk_cnt != 6'h3f)
               sclk_cnt <= sclk_cnt + 6'h01;
         end
         if (!(state == ST_SAMPLE && ext_smp))
            gap_cnt <= '0;
         else if (gap_cnt != 7'h7f)
            gap_cnt <= gap_cnt + 7'h01;
      end
   end

   // Extended mode entry and two-select exit
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_mode_o <= 1'b0;
         cs_fall_seen <= 1'b0;
      end
      else if (state == ST_SAMPLE && ext_smp)
      begin
         ext_mode_o <= 1'b1;
         cs_fall_seen <= 1'b0;
      end
      else if (ext_mode_o && !pin_sync.ext_sample_start_n)
         cs_fall_seen <= 1'b0;
      else if (ext_mode_o && cs_fall)
      begin
         if (cs_fall_seen)
         begin
            ext_mode_o <= 1'b0; // [R09]
            cs_fall_seen <= 1'b0;
         end
         else
            cs_fall_seen <= 1'b1;
      end
   end

   // Result buffer, flags, power-down
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         result_o <= '0;
         result_valid_o <= 1'b0;
         int_n_o <= 1'b1;
         pwrdn_o <= 1'b0;
      end
      else
      begin
         if (conv_done && oneshot)
         begin
            result_o <= conv_data_i; // [R19]
            result_valid_o <= 1'b1;
            int_n_o <= cfg_i.eoc_sel;
         end
         else
         begin
            if (cmd_done && (is_conv_cmd(cmd_next) || cmd_next == CMD_FIFO_READ))
               result_valid_o <= 1'b0; // [R08]
            if (frame_start)
               int_n_o <= 1'b1;
         end
         if (cmd_done && cmd_next == CMD_PWRDN)
            pwrdn_o <= 1'b1; // [R14]
         else if (cmd_done && is_conv_cmd(cmd_next))
            pwrdn_o <= 1'b0;
      end
   end

   assign sampling_o = state == ST_SAMPLE && !(ext_pend && !ext_smp);
   assign converting_o = state == ST_CONV;
   assign eoc_o = cfg_i.eoc_sel && state == ST_CONV; // [R19]
   assign fifo_flush = cmd_done && is_conv_cmd(cmd_next) && cfg_i.conv_mode == MODE_REPEAT; // [R20] [R21]

   adct_fifo #(
      .WIDTH(RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(fifo_flush),
      .in_valid_i(conv_done && !oneshot), // [R20]
      .in_ready_o(push_ready),
      .in_data_i(conv_data_i),
      .out_valid_o(fifo_valid_o),
      .out_ready_i(fifo_ready_i),
      .out_data_o(fifo_data_o)
   );

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_cmd_gate;
      cmd_done && !is_conv_cmd(cmd_next) |=> state == ST_IDLE;
   endproperty
   a_cmd_gate: assert property (p_cmd_gate) else $error("sampling without conversion command"); // [R01]

   property p_start_edge;
      $rose(converting_o) && !$past(ext_smp) |-> edge_cnt == start_edge;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("conversion at wrong SCLK edge"); // [R11]

   property p_ext_start;
      state == ST_IDLE && ext_fall && cs_high && ext_ok |=> sampling_o && ext_smp;
   endproperty
   a_ext_start: assert property (p_ext_start) else $error("start pin fall did not sample"); // [R04]

   property p_ext_end;
      state == ST_SAMPLE && ext_smp && ext_rise |=> converting_o && !sampling_o;
   endproperty
   a_ext_end: assert property (p_ext_end) else $error("start pin rise did not convert"); // [R07]

   property p_ref_gate;
      state == ST_IDLE && ext_fall && !ext_ok && !frame_start |=> state == ST_IDLE;
   endproperty
   a_ref_gate: assert property (p_ref_gate) else $error("pin trigger without internal ref"); // [R10]

   property p_int_time;
      converting_o && oneshot && cfg_i.conv_clk == CLK_INTERNAL
         && conv_cnt == 7'(CONV_INT_CYC) |=> !converting_o;
   endproperty
   a_int_time: assert property (p_int_time) else $error("internal clock conversion too long"); // [R12]

   property p_sclk_conv;
      conv_done && cfg_i.conv_clk != CLK_INTERNAL |=> sclk_cnt >= sclk_conv_edges($past(cfg_i.conv_clk));
   endproperty
   a_sclk_conv: assert property (p_sclk_conv) else $error("SCLK conversion ended early"); // [R13]

   property p_ext_exit;
      ext_mode_o && cs_fall && cs_fall_seen && pin_sync.ext_sample_start_n
         && !(state == ST_SAMPLE && ext_smp) |=> !ext_mode_o;
   endproperty
   a_ext_exit: assert property (p_ext_exit) else $error("extended mode not left"); // [R09]

   property p_oneshot_result;
      conv_done && oneshot |=> result_valid_o && result_o == $past(conv_data_i) && !fifo_valid_o[*1];
   endproperty
   a_oneshot_result: assert property (p_oneshot_result) else $error("one-shot result not buffered"); // [R19]

   c_normal: cover property ($rose(converting_o) && !$past(ext_smp));
   c_ext: cover property (ext_smp && ext_rise);
   c_pend: cover property (ext_pend && cs_rise);
   c_exit: cover property ($fell(ext_mode_o));
endmodule

// File: rtl/adct_fifo.sv
// Purpose: result FIFO with valid/ready on both sides
// Assumes: single clock, flush drops all words
// Notes: write is refused while full
`timescale 1ns/1ps
module adct_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (flush_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule
